// *** verilog/fss_pkg.sv ***
// package: register map, field positions and carrier types of the frame sync status block
package fss_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int FSS_ADDR_W = 8;
  localparam int FSS_DATA_W = 32;
  localparam logic [1:0] FSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FSS_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] FSS_IDX_MULT = 6'h07;
  localparam logic [5:0] FSS_IDX_RST_LEN = 6'h08;
  localparam logic [5:0] FSS_IDX_INTEG = 6'h09;
  localparam logic [5:0] FSS_IDX_INTEG2 = 6'h0a;
  localparam logic [5:0] FSS_IDX_INTEG3 = 6'h0b;
  localparam logic [5:0] FSS_IDX_GAIN = 6'h0c;
  localparam logic [5:0] FSS_IDX_SYNC = 6'h0e;
  localparam logic [5:0] FSS_IDX_RB_MULT = 6'h10;
  localparam logic [5:0] FSS_IDX_RB_RST_LEN = 6'h11;
  localparam logic [5:0] FSS_IDX_RB_INTEG = 6'h12;
  localparam logic [5:0] FSS_IDX_RB_INTEG2 = 6'h13;
  localparam logic [5:0] FSS_IDX_RB_INTEG3 = 6'h14;
  localparam logic [5:0] FSS_IDX_RB_GAIN = 6'h15;
  localparam logic [5:0] FSS_IDX_MODE = 6'h30;
  localparam logic [5:0] FSS_IDX_WIN = 6'h31;
  localparam logic [5:0] FSS_IDX_STAT = 6'h32;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int FSS_SYNC_INTEG_BIT = 3;
  localparam int FSS_SYNC_GAIN_BIT = 4;
  localparam int FSS_SYNC_ROI_BIT = 5;
  localparam int FSS_BLANK_ROI_BIT = 8;
  localparam int FSS_BLANK_SUB_BIT = 9;
  localparam int FSS_LATCH_MODE_BIT = 10;
  localparam int FSS_MODE_ROLLING_BIT = 0;
  localparam int FSS_MODE_SLAVE_BIT = 1;
  localparam int FSS_MODE_TRIG_BIT = 2;
  localparam logic [15:0] FSS_SYNC_RST = 16'h033f;
  localparam logic [15:0] FSS_MULT_RST = 16'h0001;
  localparam logic [15:0] FSS_GAIN_RST = 16'h01e2;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [FSS_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [FSS_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [FSS_ADDR_W-1:0] araddr;
    logic rready;
  } fss_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [FSS_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } fss_axi_rsp_t;

  typedef struct packed {
    logic [15:0] mult;
    logic [15:0] rst_len;
    logic [15:0] integ;
    logic [15:0] second_slope_integration;
    logic [15:0] third_slope_integration;
  } fss_integ_t;

  typedef struct packed {
    logic [1:0] sub;
    logic [7:0] roi;
  } fss_win_t;

  typedef struct packed {
    logic [15:0] cnt;
  } fss_tick_t;

  typedef struct packed {
    fss_integ_t cfg_integ;
    fss_integ_t live_integ;
    logic [15:0] cfg_gain;
    logic [15:0] live_gain;
    logic [15:0] sync;
    logic [2:0] mode;
    fss_win_t cfg_win;
    fss_win_t live_win;
    logic blank_pend;
    logic frame_blank;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [FSS_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [FSS_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } fss_state_t;

endpackage : fss_pkg

// *** verilog/fss_unit_tick.sv ***
// module: timebase unit divider, one enable pulse per multiplier count
`timescale 1ns/1ns
module fss_unit_tick
  import fss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] mult,
  output logic tick
);

  fss_tick_t s_q;
  fss_tick_t s_d;

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  // a multiplier of zero behaves as one: a pulse every cycle
  always_comb begin
    s_d = s_q;
    tick = ({1'b0, s_q.cnt} + 17'h00001) >= {1'b0, mult};
    if (tick) begin
      s_d.cnt = 16'h0000;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && mult > 16'h0001 |=> !tick || $changed(mult))
    else $error("unit tick repeated inside one multiplier period");

endmodule : fss_unit_tick

// *** verilog/fss_regs.sv ***
// module: frame aligned configuration registers and live status readback over AXI4-Lite
`timescale 1ns/1ns
module fss_regs
  import fss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire fss_axi_req_t s_axi_req,
  output fss_axi_rsp_t s_axi_rsp,
  input wire logic frame_start,
  input wire logic frame_overhead_time_start,
  input wire logic integ_start,
  output fss_integ_t live_integ_o,
  output logic [15:0] live_gain_o,
  output fss_win_t live_win_o,
  output logic frame_blank_o,
  output logic unit_tick_o
);

  fss_state_t q;
  fss_state_t d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] fss_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : fss_merge

  logic rolling;
  logic slave;
  logic trig_gs_master;
  logic integ_apply;
  logic gain_apply;
  logic win_apply;
  logic blank_now;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [5:0] w_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [5:0] r_idx;
  logic [15:0] m16;

  assign rolling = q.mode[FSS_MODE_ROLLING_BIT];
  assign slave = q.mode[FSS_MODE_SLAVE_BIT];
  assign trig_gs_master = q.mode[FSS_MODE_TRIG_BIT] && !slave && !rolling;

  // ------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------
  assign s_axi_rsp.awready = !q.aw_held && !q.bvalid;
  assign s_axi_rsp.wready = !q.w_held && !q.bvalid;
  assign s_axi_rsp.arready = !q.rvalid;
  assign s_axi_rsp.bvalid = q.bvalid;
  assign s_axi_rsp.bresp = q.bresp;
  assign s_axi_rsp.rvalid = q.rvalid;
  assign s_axi_rsp.rdata = q.rdata;
  assign s_axi_rsp.rresp = q.rresp;

  assign aw_take = s_axi_req.awvalid && s_axi_rsp.awready;
  assign w_take = s_axi_req.wvalid && s_axi_rsp.wready;
  assign ar_take = s_axi_req.arvalid && s_axi_rsp.arready;
  assign w_idx = q.aw_held ? q.aw_idx : s_axi_req.awaddr[7:2];
  assign w_data = q.w_held ? q.wdata : s_axi_req.wdata;
  assign w_strb = q.w_held ? q.wstrb : s_axi_req.wstrb;
  assign r_idx = s_axi_req.araddr[7:2];

  // ------------------------------------------------------------
  // update alignment
  // ------------------------------------------------------------
  always_comb begin
    if (!q.sync[FSS_LATCH_MODE_BIT]) begin
      integ_apply = !q.sync[FSS_SYNC_INTEG_BIT] || frame_overhead_time_start;
    end else if (!q.sync[FSS_SYNC_INTEG_BIT]) begin
      integ_apply = 1'b0;
    end else if (trig_gs_master) begin
      integ_apply = integ_start;
    end else begin
      integ_apply = 1'b1;
    end
  end

  assign gain_apply = !q.sync[FSS_SYNC_GAIN_BIT] || frame_start;
  assign win_apply = !q.sync[FSS_SYNC_ROI_BIT] || frame_start;

  always_comb begin
    blank_now = 1'b0;
    if (win_apply) begin
      if (q.cfg_win.roi != q.live_win.roi && q.sync[FSS_BLANK_ROI_BIT]) begin
        blank_now = 1'b1;
      end
      if (q.cfg_win.sub != q.live_win.sub && (rolling || q.sync[FSS_BLANK_SUB_BIT])) begin
        blank_now = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    m16 = 16'h0000;

    if (integ_apply) begin
      d.live_integ = q.cfg_integ;
    end
    if (gain_apply) begin
      d.live_gain = q.cfg_gain;
    end
    if (win_apply) begin
      d.live_win = q.cfg_win;
    end
    // a switch that lands on a frame start blanks that frame itself
    if (frame_start) begin
      d.frame_blank = q.blank_pend || blank_now;
      d.blank_pend = 1'b0;
    end else if (blank_now) begin
      d.blank_pend = 1'b1;
    end

    // write channel
    if (aw_take) begin
      d.aw_held = 1'b1;
      d.aw_idx = s_axi_req.awaddr[7:2];
    end
    if (w_take) begin
      d.w_held = 1'b1;
      d.wdata = s_axi_req.wdata;
      d.wstrb = s_axi_req.wstrb;
    end
    if ((q.aw_held || aw_take) && (q.w_held || w_take)) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = FSS_RESP_OKAY;
      case (w_idx)
        FSS_IDX_MULT: begin
          d.cfg_integ.mult = fss_merge(q.cfg_integ.mult, w_data, w_strb);
        end
        FSS_IDX_RST_LEN: begin
          d.cfg_integ.rst_len = fss_merge(q.cfg_integ.rst_len, w_data, w_strb);
        end
        FSS_IDX_INTEG: begin
          d.cfg_integ.integ = fss_merge(q.cfg_integ.integ, w_data, w_strb);
        end
        FSS_IDX_INTEG2: begin
          d.cfg_integ.second_slope_integration = fss_merge(q.cfg_integ.second_slope_integration, w_data, w_strb);
        end
        FSS_IDX_INTEG3: begin
          d.cfg_integ.third_slope_integration = fss_merge(q.cfg_integ.third_slope_integration, w_data, w_strb);
        end
        FSS_IDX_GAIN: begin
          d.cfg_gain = fss_merge(q.cfg_gain, w_data, w_strb);
        end
        FSS_IDX_SYNC: begin
          d.sync = fss_merge(q.sync, w_data, w_strb);
        end
        FSS_IDX_MODE: begin
          m16 = fss_merge({13'h0000, q.mode}, w_data, w_strb);
          d.mode = m16[2:0];
        end
        FSS_IDX_WIN: begin
          m16 = fss_merge({6'h00, q.cfg_win}, w_data, w_strb);
          d.cfg_win = m16[9:0];
        end
        FSS_IDX_RB_MULT, FSS_IDX_RB_RST_LEN, FSS_IDX_RB_INTEG, FSS_IDX_RB_INTEG2,
        FSS_IDX_RB_INTEG3, FSS_IDX_RB_GAIN, FSS_IDX_STAT: begin
          d.bresp = FSS_RESP_OKAY;
        end
        default: begin
          d.bresp = FSS_RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && s_axi_req.bready) begin
      d.bvalid = 1'b0;
    end

    // read channel
    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rresp = FSS_RESP_OKAY;
      d.rdata = '0;
      case (r_idx)
        FSS_IDX_MULT: begin
          d.rdata[15:0] = q.cfg_integ.mult;
        end
        FSS_IDX_RST_LEN: begin
          d.rdata[15:0] = q.cfg_integ.rst_len;
        end
        FSS_IDX_INTEG: begin
          d.rdata[15:0] = q.cfg_integ.integ;
        end
        FSS_IDX_INTEG2: begin
          d.rdata[15:0] = q.cfg_integ.second_slope_integration;
        end
        FSS_IDX_INTEG3: begin
          d.rdata[15:0] = q.cfg_integ.third_slope_integration;
        end
        FSS_IDX_GAIN: begin
          d.rdata[15:0] = q.cfg_gain;
        end
        FSS_IDX_SYNC: begin
          d.rdata[15:0] = q.sync;
        end
        FSS_IDX_MODE: begin
          d.rdata[2:0] = q.mode;
        end
        FSS_IDX_WIN: begin
          d.rdata[9:0] = q.cfg_win;
        end
        FSS_IDX_RB_MULT: begin
          d.rdata[15:0] = (!slave && !rolling) ? q.live_integ.mult : 16'h0000;
        end
        FSS_IDX_RB_RST_LEN: begin
          d.rdata[15:0] = slave ? 16'h0000 : q.live_integ.rst_len;
        end
        FSS_IDX_RB_INTEG: begin
          d.rdata[15:0] = slave ? 16'h0000 : q.live_integ.integ;
        end
        FSS_IDX_RB_INTEG2: begin
          d.rdata[15:0] = slave ? 16'h0000 : q.live_integ.second_slope_integration;
        end
        FSS_IDX_RB_INTEG3: begin
          d.rdata[15:0] = slave ? 16'h0000 : q.live_integ.third_slope_integration;
        end
        FSS_IDX_RB_GAIN: begin
          d.rdata[15:0] = q.live_gain;
        end
        FSS_IDX_STAT: begin
          d.rdata[2:0] = {q.cfg_win != q.live_win, q.cfg_integ != q.live_integ, q.frame_blank};
        end
        default: begin
          d.rresp = FSS_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_req.rready) begin
      d.rvalid = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.sync <= FSS_SYNC_RST;
      q.cfg_integ.mult <= FSS_MULT_RST;
      q.cfg_gain <= FSS_GAIN_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign live_integ_o = q.live_integ;
  assign live_gain_o = q.live_gain;
  assign live_win_o = q.live_win;
  assign frame_blank_o = q.frame_blank;

  fss_unit_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .mult(q.live_integ.mult),
    .tick(unit_tick_o)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_win_immediate: assert property (
    !q.sync[FSS_SYNC_ROI_BIT] |=> q.live_win == $past(q.cfg_win))
    else $error("window change not applied immediately");

  a_win_deferred: assert property (
    q.sync[FSS_SYNC_ROI_BIT] && !frame_start |=> $stable(q.live_win))
    else $error("aligned window changed outside frame start");

  a_roi_blank: assert property (
    frame_start && q.sync[FSS_SYNC_ROI_BIT] && q.sync[FSS_BLANK_ROI_BIT] && q.cfg_win.roi != q.live_win.roi
    |=> frame_blank_o)
    else $error("frame after roi switch not blanked");

  a_sub_blank_rolling: assert property (
    frame_start && q.sync[FSS_SYNC_ROI_BIT] && rolling && q.cfg_win.sub != q.live_win.sub |=> frame_blank_o)
    else $error("rolling shutter subsample switch not blanked");

  a_fot_latch: assert property (
    !q.sync[FSS_LATCH_MODE_BIT] && q.sync[FSS_SYNC_INTEG_BIT] && !frame_overhead_time_start
    |=> $stable(live_integ_o))
    else $error("integration latched outside overhead start");

  a_cont_track: assert property (
    q.sync[FSS_LATCH_MODE_BIT] && q.sync[FSS_SYNC_INTEG_BIT] && !trig_gs_master
    |=> live_integ_o == $past(q.cfg_integ))
    else $error("continuous latch not tracking writes");

  a_trig_latch: assert property (
    q.sync[FSS_LATCH_MODE_BIT] && q.sync[FSS_SYNC_INTEG_BIT] && trig_gs_master && integ_start
    |=> live_integ_o == $past(q.cfg_integ))
    else $error("integration not taken at integration start");

  a_cont_defer: assert property (
    q.sync[FSS_LATCH_MODE_BIT] && !q.sync[FSS_SYNC_INTEG_BIT] |=> $stable(live_integ_o))
    else $error("continuous latch ignored alignment bit");

  a_integ_now: assert property (
    !q.sync[FSS_LATCH_MODE_BIT] && !q.sync[FSS_SYNC_INTEG_BIT] |=> live_integ_o == $past(q.cfg_integ))
    else $error("unaligned integration update deferred");

  a_mult_hidden: assert property (
    ar_take && r_idx == FSS_IDX_RB_MULT && (slave || rolling) |=> s_axi_rsp.rvalid && s_axi_rsp.rdata == 32'h0)
    else $error("multiplier readback shown outside master global");

  a_slave_hidden: assert property (
    ar_take && r_idx >= FSS_IDX_RB_RST_LEN && r_idx <= FSS_IDX_RB_INTEG3 && slave
    |=> s_axi_rsp.rdata == 32'h0)
    else $error("slave mode readback not zero");

  a_ro_write: assert property (
    (q.aw_held || aw_take) && (q.w_held || w_take) && w_idx >= FSS_IDX_RB_MULT && w_idx <= FSS_IDX_RB_GAIN
    |=> $stable(q.cfg_integ) && $stable(q.cfg_gain) && $stable(q.sync) && s_axi_rsp.bresp == FSS_RESP_OKAY)
    else $error("write reached a readback word");

  c_roi_blank: cover property (frame_start && blank_now);
  c_trig_latch: cover property (trig_gs_master && q.sync[FSS_LATCH_MODE_BIT] && integ_start);
  c_read_live: cover property (ar_take && r_idx == FSS_IDX_RB_INTEG ##1 s_axi_rsp.rvalid);

endmodule : fss_regs

// *** verif/fss_regs_test.sv ***
// testbench: register access, latching, readback and blanking checks of the frame sync status block
`timescale 1ns/1ns
module fss_regs_test
  import fss_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  fss_axi_req_t req = '0;
  fss_axi_rsp_t rsp;
  logic fs = 1'b0;
  logic frame_overhead_time = 1'b0;
  logic ist = 1'b0;
  fss_integ_t live;
  logic [15:0] gain;
  fss_win_t win;
  logic blank;
  logic tick;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  always #50 aclk = ~aclk;

  fss_regs u_fss_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
    .frame_start(fs), .frame_overhead_time_start(frame_overhead_time), .integ_start(ist),
    .live_integ_o(live), .live_gain_o(gain), .live_win_o(win),
    .frame_blank_o(blank), .unit_tick_o(tick)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [1:0] er = FSS_RESP_OKAY);
    logic ta;
    logic tw;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= {i, 2'h0};
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end while ((req.awvalid && !ta) || (req.wvalid && !tw));
    do @(negedge aclk); while (rsp.bvalid !== 1'b1);
    chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
    @(posedge aclk);
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] i, input logic [15:0] e, input logic [1:0] er = FSS_RESP_OKAY);
    logic t;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= {i, 2'h0};
    req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = rsp.arready;
      @(posedge aclk);
    end while (t !== 1'b1);
    req.arvalid <= 1'b0;
    do @(negedge aclk); while (rsp.rvalid !== 1'b1);
    chk("rdata", rsp.rdata, {16'h0000, e});
    chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
    @(posedge aclk);
    req.rready <= 1'b0;
  endtask : rd

  // k: 0 frame start, 1 overhead start, 2 integration start
  task automatic pulse(input int k);
    @(posedge aclk);
    if (k == 0) fs <= 1'b1;
    else if (k == 1) frame_overhead_time <= 1'b1;
    else ist <= 1'b1;
    @(posedge aclk);
    fs <= 1'b0;
    frame_overhead_time <= 1'b0;
    ist <= 1'b0;
    @(negedge aclk);
  endtask : pulse

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask : wait_cyc

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rd(FSS_IDX_RB_MULT + 6'(i), 16'h0000);
    end
    rd(FSS_IDX_SYNC, FSS_SYNC_RST);
    chk("gain reset", {16'h0, gain}, 32'h0);
  endtask : t_reset

  task automatic t_access();
    wr(FSS_IDX_RB_INTEG, 16'h1234);
    rd(FSS_IDX_RB_INTEG, 16'h0000);
    wr(6'h3f, 16'h00ff, FSS_RESP_SLVERR);
    rd(6'h3f, 16'h0000, FSS_RESP_SLVERR);
  endtask : t_access

  task automatic t_fot_latch();
    int n;
    wr(FSS_IDX_MULT, 16'h0003);
    wr(FSS_IDX_RST_LEN, 16'h0007);
    wr(FSS_IDX_INTEG, 16'h0005);
    wr(FSS_IDX_INTEG2, 16'h0006);
    wr(FSS_IDX_INTEG3, 16'h0008);
    wait_cyc(4);
    chk("integ held", {16'h0, live.integ}, 32'h0);
    pulse(1);
    chk("integ at fot", {16'h0, live.integ}, 32'h5);
    rd(FSS_IDX_RB_MULT, 16'h0003);
    rd(FSS_IDX_RB_RST_LEN, 16'h0007);
    rd(FSS_IDX_RB_INTEG, 16'h0005);
    rd(FSS_IDX_RB_INTEG2, 16'h0006);
    rd(FSS_IDX_RB_INTEG3, 16'h0008);
    n = 0;
    for (int i = 0; i < 30; i++) begin
      @(negedge aclk);
      if (tick === 1'b1) n++;
    end
    chk("ticks", 32'(n), 32'd10);
  endtask : t_fot_latch

  task automatic t_modes();
    wr(FSS_IDX_MODE, 16'h0002);
    rd(FSS_IDX_RB_MULT, 16'h0000);
    rd(FSS_IDX_RB_RST_LEN, 16'h0000);
    rd(FSS_IDX_RB_INTEG, 16'h0000);
    rd(FSS_IDX_RB_INTEG3, 16'h0000);
    wr(FSS_IDX_MODE, 16'h0001);
    rd(FSS_IDX_RB_MULT, 16'h0000);
    rd(FSS_IDX_RB_RST_LEN, 16'h0007);
    wr(FSS_IDX_MODE, 16'h0000);
  endtask : t_modes

  task automatic t_latch_modes();
    wr(FSS_IDX_SYNC, 16'h0337);
    wr(FSS_IDX_INTEG, 16'h0009);
    wait_cyc(3);
    chk("integ direct", {16'h0, live.integ}, 32'h9);
    wr(FSS_IDX_SYNC, 16'h0737);
    wr(FSS_IDX_INTEG, 16'h000b);
    wait_cyc(3);
    pulse(1);
    chk("integ deferred", {16'h0, live.integ}, 32'h9);
    wr(FSS_IDX_SYNC, 16'h073f);
    wait_cyc(3);
    chk("integ tracks", {16'h0, live.integ}, 32'hb);
    wr(FSS_IDX_INTEG, 16'h000c);
    wait_cyc(3);
    chk("integ tracks 2", {16'h0, live.integ}, 32'hc);
  endtask : t_latch_modes

  task automatic t_trig();
    wr(FSS_IDX_MODE, 16'h0004);
    wr(FSS_IDX_INTEG, 16'h000d);
    wait_cyc(3);
    chk("trig wait", {16'h0, live.integ}, 32'hc);
    pulse(1);
    chk("trig no fot", {16'h0, live.integ}, 32'hc);
    pulse(2);
    chk("trig at integ", {16'h0, live.integ}, 32'hd);
    wr(FSS_IDX_SYNC, FSS_SYNC_RST);
    wr(FSS_IDX_MODE, 16'h0000);
  endtask : t_trig

  task automatic t_roi();
    wr(FSS_IDX_WIN, 16'h0005);
    wait_cyc(3);
    chk("roi deferred", {24'h0, win.roi}, 32'h0);
    pulse(0);
    chk("roi at frame", {24'h0, win.roi}, 32'h5);
    chk("gain loaded", {16'h0, gain}, {16'h0, FSS_GAIN_RST});
    rd(FSS_IDX_RB_GAIN, FSS_GAIN_RST);
    chk("blank roi", {31'h0, blank}, 32'h1);
    pulse(0);
    chk("blank ends", {31'h0, blank}, 32'h0);
    wr(FSS_IDX_SYNC, 16'h031f);
    wr(FSS_IDX_WIN, 16'h0006);
    wait_cyc(3);
    chk("roi direct", {24'h0, win.roi}, 32'h6);
    pulse(0);
    chk("blank pending", {31'h0, blank}, 32'h1);
  endtask : t_roi

  task automatic t_sub();
    wr(FSS_IDX_SYNC, 16'h011f);
    pulse(0);
    chk("blank clear", {31'h0, blank}, 32'h0);
    wr(FSS_IDX_WIN, 16'h0106);
    pulse(0);
    chk("sub global", {31'h0, blank}, 32'h0);
    wr(FSS_IDX_MODE, 16'h0001);
    wr(FSS_IDX_WIN, 16'h0206);
    pulse(0);
    chk("sub rolling", {31'h0, blank}, 32'h1);
    chk("sub live", {30'h0, win.sub}, 32'h2);
    wr(FSS_IDX_MODE, 16'h0000);
    wr(FSS_IDX_SYNC, 16'h031f);
    pulse(0);
    chk("blank clear 2", {31'h0, blank}, 32'h0);
    wr(FSS_IDX_WIN, 16'h0306);
    pulse(0);
    chk("sub global bit", {31'h0, blank}, 32'h1);
    rd(FSS_IDX_STAT, 16'h0001);
  endtask : t_sub

  // ------------------------------------------------------------
  // sequence and timeout
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_access();
    t_fot_latch();
    t_modes();
    t_latch_modes();
    t_trig();
    t_roi();
    t_sub();
    end_of_test();
  end
endmodule : fss_regs_test
